// ==== design/pib_bridge.sv ====
//==============================================================================
// Purpose: error status, system error, retry control of a pci-to-isa bridge
// Assumes: pci decode and isa engines on the same clock; pins pass 2 flops
// Notes:   status register reached by type 0 config reads at its offset
//
// Overview of operation
// - read-only 8-bit status, offset 42h, reset zero
// - bit 2 is inverse of the iochk_n pin
// - channel check set pulses serr if enabled
// - bit 0 set on illegal i/o lanes
// - illegal lanes: target abort, serr if enabled
// - every i/o transaction has lanes checked
// - illegal i/o never reaches isa bus
// - no bursts, disconnect after first transfer
// - serr only from channel check, lane error
// - isa master pci cycles: memory only
// - isa master i/o never forwarded to pci
// - refresh on 15 us timer or request
// - pc/pci dma cycles become isa dma
// - dma active: retry pci accesses to us
// - retried master cycle releases the bus
// - passive retry: retry isa-bound accesses with legal lanes
// - leave passive retry after regrant and completion
`timescale 1ns/1ps
`default_nettype none
module pib_bridge
#(
  parameter int REFRESH_PERIOD = pib_pkg::REFRESH_CYC
)
(
  // clock, reset, enable
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  input  wire logic                  ce,
  // isa pins
  input  wire logic                  iochk_n,
  input  wire logic                  isa_refresh_req_n,
  // system error pin, open drain
  output logic                       serr_o_ff,
  output logic                       serr_oe_ff,
  // pci command register bit
  input  wire logic                  serr_enable,
  // pci target side
  input  wire pib_pkg::pib_tgt_req_t tgt_req,
  output pib_pkg::pib_tgt_rsp_t      tgt_rsp_ff,
  // isa cycle engine
  output pib_pkg::pib_isa_cyc_t      isa_cyc_ff,
  input  wire logic                  isa_done,
  output logic                       refresh_start_ff,
  // dma agents
  input  wire logic                  isa_dma_active,
  input  wire logic                  pcpci_dma_active,
  input  wire logic                  pcpci_dma_cycle,
  input  wire logic [2:0]            pcpci_dma_chan,
  output logic                       isa_dma_start_ff,
  output logic [2:0]                 isa_dma_chan_ff,
  // isa master / dma requests for pci master cycles
  input  wire pib_pkg::pib_mst_req_t ism_req,
  output logic                       ism_reject_ff,
  // pci master engine
  output logic                       mst_req_ff,
  output logic [31:0]                mst_addr_ff,
  output logic                       mst_write_ff,
  input  wire logic                  mst_gnt,
  input  wire logic                  mst_retry,
  input  wire logic                  mst_done,
  output logic                       mst_complete_ff,
  // status view
  output logic [7:0]                 status_ff,
  output logic                       passive_retry_ff
);

  //============================================================================
  // pin synchronisers
  logic iochk_s1_ff;
  logic iochk_s2_ff;
  logic rfq_s1_ff;
  logic rfq_s2_ff;
  logic rfq_prev_ff;

  // two flops for each pin
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      iochk_s1_ff <= 1'b1;
      iochk_s2_ff <= 1'b1;
      rfq_s1_ff   <= 1'b1;
      rfq_s2_ff   <= 1'b1;
      rfq_prev_ff <= 1'b1;
    end
    else if (ce)
    begin
      iochk_s1_ff <= iochk_n;
      iochk_s2_ff <= iochk_s1_ff;
      rfq_s1_ff   <= isa_refresh_req_n;
      rfq_s2_ff   <= rfq_s1_ff;
      rfq_prev_ff <= rfq_s2_ff;
    end
  end

  //============================================================================
  // byte lane check and refresh timer
  logic lanes_legal;
  logic refresh_tick;

  pib_byte_check u_check
  (
    .addr_lo (tgt_req.addr[1:0]),
    .be_n    (tgt_req.be_n),
    .legal   (lanes_legal)
  );

  pib_refresh_timer #(.PERIOD(REFRESH_PERIOD)) u_rtimer
  (
    .clk     (clk),
    .sys_rst (sys_rst),
    .ce      (ce),
    .tick_ff (refresh_tick)
  );

  //============================================================================
  // target decode
  typedef enum logic [0:0] { T_IDLE, T_ISA } pib_tst_t;
  typedef enum logic [1:0] { M_IDLE, M_RUN, M_PASSIVE, M_REGRANT } pib_mst_t;

  pib_tst_t t_state_ff;
  pib_tst_t nxt_t_state;
  pib_mst_t m_state_ff;
  pib_mst_t nxt_m_state;

  logic       chk_now;
  logic       is_io;
  logic       is_cfg;
  logic       lane_err;
  logic       dma_busy;
  logic       do_retry;
  logic       do_abort;
  logic       do_cfg;
  logic       do_isa;
  logic       sts_hit;
  logic       chk_rise;
  logic       serr_event;
  logic [7:0] nxt_status;

  assign chk_now  = ~iochk_s2_ff;
  assign chk_rise = chk_now & ~status_ff[pib_pkg::STS_IOCHK];
  assign is_io    = (tgt_req.cmd == pib_pkg::CMD_IO_RD) |
                    (tgt_req.cmd == pib_pkg::CMD_IO_WR);
  assign is_cfg   = tgt_req.cfg_type0 &
                    ((tgt_req.cmd == pib_pkg::CMD_CFG_RD) |
                     (tgt_req.cmd == pib_pkg::CMD_CFG_WR));
  // only i/o requests checked, only i/o is aborted
  assign lane_err = tgt_req.valid & is_io & ~lanes_legal;
  assign dma_busy = isa_dma_active | pcpci_dma_active;
  // priority: dma busy, lane error, passive retry, config, isa
  assign do_retry = tgt_req.valid & (t_state_ff == T_IDLE) &
                    (dma_busy |
                     (passive_retry_ff & tgt_req.to_isa &
                      ~lane_err));
  assign do_abort = (t_state_ff == T_IDLE) & lane_err & ~dma_busy;
  assign do_cfg   = tgt_req.valid & (t_state_ff == T_IDLE) & is_cfg &
                    ~do_retry & ~do_abort;
  assign do_isa   = tgt_req.valid & (t_state_ff == T_IDLE) & tgt_req.to_isa &
                    ~is_cfg & ~do_retry & ~do_abort;
  assign sts_hit  = (tgt_req.addr[7:2] == pib_pkg::STS_OFFSET[7:2]);

  //============================================================================
  // status register, serr sources
  // bit 2 follows the pin, bit 0 sticky, others zero
  always_comb
  begin
    nxt_status                        = pib_pkg::STS_RESET;
    nxt_status[pib_pkg::STS_IOCHK]    = chk_now;
    nxt_status[pib_pkg::STS_BYTE_ERR] = status_ff[pib_pkg::STS_BYTE_ERR] |
                                        do_abort;
  end

  // only two causes may raise serr
  assign serr_event = serr_enable & (chk_rise | do_abort);

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      status_ff  <= pib_pkg::STS_RESET;
      serr_o_ff  <= 1'b0;
      serr_oe_ff <= 1'b0;
    end
    else if (ce)
    begin
      status_ff  <= nxt_status;
      serr_oe_ff <= serr_event;
    end
  end

  //============================================================================
  // target state machine
  always_comb
  begin
    nxt_t_state = t_state_ff;
    case (t_state_ff)
      T_IDLE:
        if (do_isa)
          nxt_t_state = T_ISA;
      T_ISA:
        if (isa_done)
          nxt_t_state = T_IDLE;
      default:
        nxt_t_state = T_IDLE;
    endcase
  end

  pib_pkg::pib_tgt_rsp_t nxt_rsp;
  logic [31:0]           cfg_rdata;

  // status sits in byte lane 2 of its dword
  assign cfg_rdata = sts_hit ?
                     {8'h00, status_ff, 16'h0000} : 32'h0000_0000;

  // answer: one cycle pulse, always with disconnect
  always_comb
  begin
    nxt_rsp              = '0;
    nxt_rsp.done         = do_retry | do_abort | do_cfg |
                           ((t_state_ff == T_ISA) & isa_done);
    nxt_rsp.retry        = do_retry;
    nxt_rsp.target_abort = do_abort;
    nxt_rsp.disconnect   = nxt_rsp.done;
    // config writes land nowhere: register is read only
    nxt_rsp.rdata        = (do_cfg & (tgt_req.cmd == pib_pkg::CMD_CFG_RD)) ?
                           cfg_rdata : 32'h0000_0000;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      t_state_ff <= T_IDLE;
      tgt_rsp_ff <= '0;
      isa_cyc_ff <= '0;
    end
    else if (ce)
    begin
      t_state_ff       <= nxt_t_state;
      tgt_rsp_ff       <= nxt_rsp;
      isa_cyc_ff.valid <= do_isa;
      if (do_isa)
      begin
        isa_cyc_ff.write <= tgt_req.cmd[0];
        isa_cyc_ff.addr  <= tgt_req.addr;
        isa_cyc_ff.be_n  <= tgt_req.be_n;
        isa_cyc_ff.wdata <= tgt_req.wdata;
      end
    end
  end

  //============================================================================
  // refresh and dma conversion
  logic rfq_fall;

  assign rfq_fall = rfq_prev_ff & ~rfq_s2_ff;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      refresh_start_ff <= 1'b0;
      isa_dma_start_ff <= 1'b0;
      isa_dma_chan_ff  <= 3'h0;
    end
    else if (ce)
    begin
      refresh_start_ff <= refresh_tick | rfq_fall;
      isa_dma_start_ff <= pcpci_dma_cycle;
      if (pcpci_dma_cycle)
        isa_dma_chan_ff <= pcpci_dma_chan;
    end
  end

  //============================================================================
  // master side and passive retry
  logic ism_accept;
  logic ism_io;

  // memory only; i/o requests are turned back
  assign ism_accept = ism_req.valid & ism_req.is_mem &
                      (m_state_ff == M_IDLE);
  assign ism_io     = ism_req.valid & ~ism_req.is_mem;

  always_comb
  begin
    nxt_m_state = m_state_ff;
    case (m_state_ff)
      M_IDLE:
        if (ism_accept)
          nxt_m_state = M_RUN;
      M_RUN:
        if (mst_retry)
          nxt_m_state = M_PASSIVE;
        else if (mst_done)
          nxt_m_state = M_IDLE;
      M_PASSIVE:
        if (mst_gnt & mst_req_ff)
          nxt_m_state = M_REGRANT;
      M_REGRANT:
        if (mst_retry)
          nxt_m_state = M_PASSIVE;
        else if (mst_done)
          nxt_m_state = M_IDLE;
      default:
        nxt_m_state = M_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      m_state_ff       <= M_IDLE;
      mst_req_ff       <= 1'b0;
      mst_addr_ff      <= 32'h0000_0000;
      mst_write_ff     <= 1'b0;
      mst_complete_ff  <= 1'b0;
      ism_reject_ff    <= 1'b0;
      passive_retry_ff <= 1'b0;
    end
    else if (ce)
    begin
      m_state_ff       <= nxt_m_state;
      // drop request for one cycle on retry, then ask again
      mst_req_ff       <= (nxt_m_state != M_IDLE) & ~mst_retry;
      mst_complete_ff  <= (m_state_ff != M_IDLE) &
                          (m_state_ff != M_PASSIVE) &
                          mst_done & ~mst_retry;
      ism_reject_ff    <= ism_io;
      passive_retry_ff <= (nxt_m_state == M_PASSIVE) |
                          (nxt_m_state == M_REGRANT);
      if (ism_accept)
      begin
        mst_addr_ff  <= ism_req.addr;
        mst_write_ff <= ism_req.write;
      end
    end
  end

endmodule
`default_nettype wire

// ==== design/pib_pkg.sv ====
//==============================================================================
// Purpose: shared constants and carriers for the bridge error/retry block
// Assumes: one clock at 125 MHz
// Notes:   status register fields, config offsets, refresh timing
package pib_pkg;

  // configuration space
  localparam logic [7:0] STS_OFFSET   = 8'h42;
  localparam logic [7:0] STS_RESET    = 8'h00;
  localparam int         STS_IOCHK    = 2;
  localparam int         STS_BYTE_ERR = 0;
  localparam int         STS_LANE     = 2;

  // pci command codes that matter here
  localparam logic [3:0] CMD_IO_RD    = 4'h2;
  localparam logic [3:0] CMD_IO_WR    = 4'h3;
  localparam logic [3:0] CMD_CFG_RD   = 4'hA;
  localparam logic [3:0] CMD_CFG_WR   = 4'hB;

  // refresh timing
  localparam int CLK_PERIOD_PS = 8000;
  localparam int REFRESH_US    = 15;
  localparam int REFRESH_CYC   = (REFRESH_US * 1000 * 1000) / CLK_PERIOD_PS;

  // request from the pci target decoder
  typedef struct packed {
    logic        valid;
    logic [3:0]  cmd;
    logic [31:0] addr;
    logic [3:0]  be_n;
    logic [31:0] wdata;
    logic        to_isa;
    logic        cfg_type0;
  } pib_tgt_req_t;

  // answer to the pci target decoder
  typedef struct packed {
    logic        done;
    logic        target_abort;
    logic        retry;
    logic        disconnect;
    logic [31:0] rdata;
  } pib_tgt_rsp_t;

  // cycle handed to the isa engine
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [31:0] addr;
    logic [3:0]  be_n;
    logic [31:0] wdata;
  } pib_isa_cyc_t;

  // isa master or dma request for a pci master cycle
  typedef struct packed {
    logic        valid;
    logic        is_mem;
    logic        write;
    logic [31:0] addr;
  } pib_mst_req_t;

endpackage

// ==== design/pib_byte_check.sv ====
//==============================================================================
// Purpose: byte lane legality check for one pci data phase
// Assumes: enables active low, addr low bits as presented on the bus
// Notes:   legal = none enabled, or one contiguous run starting at addr[1:0]
`timescale 1ns/1ps
`default_nettype none
module pib_byte_check
(
  // data phase
  input  wire logic [1:0] addr_lo,
  input  wire logic [3:0] be_n,
  // verdict
  output logic            legal
);

  logic [3:0] lane_en;
  logic [3:0] below;
  logic [3:0] shifted;
  logic       run_ok;

  // per lane: enabled and lanes under the start address
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_lane
      assign lane_en[g] = ~be_n[g];
      assign below[g]   = (2'(g) < addr_lo) & lane_en[g];
    end
  endgenerate

  assign shifted = lane_en >> addr_lo;
  assign run_ok  = (shifted == 4'h1) | (shifted == 4'h3) |
                   (shifted == 4'h7) | (shifted == 4'hF);
  assign legal   = (lane_en == 4'h0) | ((below == 4'h0) & run_ok);

endmodule
`default_nettype wire

// ==== design/pib_refresh_timer.sv ====
//==============================================================================
// Purpose: free running isa refresh interval timer
// Assumes: ce freezes the count
// Notes:   tick is a one cycle pulse every PERIOD cycles
`timescale 1ns/1ps
`default_nettype none
module pib_refresh_timer
#(
  parameter int PERIOD = pib_pkg::REFRESH_CYC
)
(
  // clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic ce,
  // expiry
  output logic      tick_ff
);

  localparam int W = $clog2(PERIOD + 1);
  localparam logic [W-1:0] LAST = W'(PERIOD - 1);

  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;
  logic         wrap;

  assign wrap    = (cnt_ff == LAST);
  assign nxt_cnt = wrap ? '0 : W'(cnt_ff + 1'b1);

  // count and pulse on wrap
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      cnt_ff  <= '0;
      tick_ff <= 1'b0;
    end
    else if (ce)
    begin
      cnt_ff  <= nxt_cnt;
      tick_ff <= wrap;
    end
  end

endmodule
`default_nettype wire

// ==== tb/pib_far_model.sv ====
//==============================================================================
// Purpose: isa engine and pci master engine seen from the bridge
// Assumes: same clock as the bridge
// Notes:   slow stretches isa_done and mst_done; arm_retry retries one master cycle
`timescale 1ns/1ps
`default_nettype none
module pib_far_model
(
  // clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // scenario control
  input  wire logic slow,
  input  wire logic arm_retry,
  // from the bridge
  input  wire logic isa_valid,
  input  wire logic mst_req,
  // answers
  output logic      isa_done,
  output logic      mst_gnt,
  output logic      mst_retry,
  output logic      mst_done
);
  logic [3:0] ic_ff;
  logic [3:0] mc_ff;
  logic       ib_ff;
  logic       arm_ff;

  // answers decoded from the counters
  assign isa_done  = ib_ff && (ic_ff == (slow ? 4'h5 : 4'h1));
  assign mst_gnt   = mst_req && !arm_ff;
  assign mst_retry = mst_req && arm_ff && (mc_ff == 4'h2);
  assign mst_done  = mst_gnt && (mc_ff == (slow ? 4'h6 : 4'h2));

  // isa wait and master ownership counters
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ib_ff  <= 1'b0;
      ic_ff  <= 4'h0;
      mc_ff  <= 4'h0;
      arm_ff <= 1'b0;
    end
    else
    begin
      ib_ff  <= isa_valid || (ib_ff && !isa_done);
      ic_ff  <= isa_valid ? 4'h0 : ic_ff + 4'h1;
      mc_ff  <= mst_req ? mc_ff + 4'h1 : 4'h0;
      arm_ff <= arm_retry || (arm_ff && !mst_retry);
    end
  end
endmodule
`default_nettype wire

// ==== tb/pib_bridge_chk.sv ====
//==============================================================================
// Purpose: port level checks of the bridge error and retry logic
// Assumes: ce held high by the bench
// Notes:   bound into every bridge instance
`timescale 1ns/1ps
`default_nettype none
module pib_bridge_chk
(
  // clock and reset
  input wire logic                  clk,
  input wire logic                  sys_rst,
  input wire logic                  ce,
  // pins and command bit
  input wire logic                  iochk_n,
  input wire logic                  serr_oe_ff,
  input wire logic                  serr_enable,
  // target side
  input wire pib_pkg::pib_tgt_req_t tgt_req,
  input wire pib_pkg::pib_tgt_rsp_t tgt_rsp_ff,
  input wire pib_pkg::pib_isa_cyc_t isa_cyc_ff,
  // dma
  input wire logic                  isa_dma_active,
  input wire logic                  pcpci_dma_active,
  input wire logic                  pcpci_dma_cycle,
  input wire logic [2:0]            pcpci_dma_chan,
  input wire logic                  isa_dma_start_ff,
  input wire logic [2:0]            isa_dma_chan_ff,
  // master side and status
  input wire pib_pkg::pib_mst_req_t ism_req,
  input wire logic                  ism_reject_ff,
  input wire logic                  mst_req_ff,
  input wire logic                  mst_retry,
  input wire logic                  mst_complete_ff,
  input wire logic [7:0]            status_ff,
  input wire logic                  passive_retry_ff
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic [2:0] up_ff;
  logic       busy_ff;

  // legal: no lanes, or one run starting at the address lane
  function automatic logic lanes_ok(input logic [1:0] a, input logic [3:0] be_n);
    logic [3:0] en;
    en = ~be_n >> a;
    return ((~be_n & ~(4'hf << a)) == 4'h0) && ((en & (en + 4'h1)) == 4'h0);
  endfunction

  // request decode
  wire io_cmd = tgt_req.cmd == pib_pkg::CMD_IO_RD || tgt_req.cmd == pib_pkg::CMD_IO_WR;
  wire bad_io = io_cmd && !lanes_ok(tgt_req.addr[1:0], tgt_req.be_n);
  wire dma    = isa_dma_active || pcpci_dma_active;
  wire take   = tgt_req.valid && !busy_ff && !isa_cyc_ff.valid;

  // cycles since reset, isa cycle outstanding
  always_ff @(posedge clk)
  begin
    up_ff   <= (sys_rst || !ce) ? 3'h0 : up_ff + {2'h0, up_ff != 3'h7};
    busy_ff <= !sys_rst && (isa_cyc_ff.valid || (busy_ff && !tgt_rsp_ff.done));
  end

  sequence s_bad_io;
    take && !dma && bad_io;
  endsequence
  sequence s_abort_rsp;
    tgt_rsp_ff.done && tgt_rsp_ff.target_abort && status_ff[0];
  endsequence

  a_status_reset: assert property (disable iff (1'b0) sys_rst |=> status_ff == 8'h00)
    else $error("status not zero after reset");
  a_resv_zero: assert property (status_ff[7:3] == 5'h00 && !status_ff[1])
    else $error("reserved status bit set");
  a_chk_follow: assert property (up_ff == 3'h7 |-> status_ff[2] == !$past(iochk_n, 3))
    else $error("channel check bit wrong");
  a_serr_iochk: assert property ($rose(status_ff[2]) && $past(serr_enable) |-> serr_oe_ff)
    else $error("no serr on channel check");
  a_serr_cause: assert property (serr_oe_ff |-> $past(serr_enable) &&
    (tgt_rsp_ff.target_abort || $rose(status_ff[2])))
    else $error("serr without cause");
  a_abort_lane: assert property (s_bad_io |=> s_abort_rsp ##0 serr_oe_ff == $past(serr_enable))
    else $error("bad lanes not aborted");
  a_abort_no_isa: assert property (s_bad_io |=> !isa_cyc_ff.valid)
    else $error("bad lanes reached isa");
  a_no_burst: assert property (tgt_rsp_ff.done |-> tgt_rsp_ff.disconnect)
    else $error("answer without disconnect");
  a_dma_retry: assert property (take && dma && (tgt_req.to_isa || tgt_req.cfg_type0)
    |=> tgt_rsp_ff.done && tgt_rsp_ff.retry && !isa_cyc_ff.valid)
    else $error("access not retried during dma");
  a_passive_retry: assert property (take && !dma && !bad_io && passive_retry_ff && tgt_req.to_isa
    |=> tgt_rsp_ff.done && tgt_rsp_ff.retry)
    else $error("isa access not retried when passive");
  a_retry_release: assert property (mst_retry && mst_req_ff |=> !mst_req_ff && passive_retry_ff)
    else $error("bus not released on retry");
  a_leave_passive: assert property ($fell(passive_retry_ff) && !$past(sys_rst) |-> mst_complete_ff)
    else $error("passive left without completion");
  a_io_refuse: assert property (ism_req.valid && !ism_req.is_mem && !mst_req_ff && !passive_retry_ff
    |=> ism_reject_ff && !mst_req_ff)
    else $error("isa master io not refused");
  a_mem_only: assert property ($rose(mst_req_ff) |->
    passive_retry_ff || $past(ism_req.valid && ism_req.is_mem))
    else $error("master cycle not for memory");
  a_dma_convert: assert property (pcpci_dma_cycle |=>
    isa_dma_start_ff && isa_dma_chan_ff == $past(pcpci_dma_chan))
    else $error("dma cycle not converted");
endmodule
bind pib_bridge pib_bridge_chk u_chk (.clk, .sys_rst, .ce, .iochk_n, .serr_oe_ff, .serr_enable,
  .tgt_req, .tgt_rsp_ff, .isa_cyc_ff, .isa_dma_active, .pcpci_dma_active, .pcpci_dma_cycle,
  .pcpci_dma_chan, .isa_dma_start_ff, .isa_dma_chan_ff, .ism_req, .ism_reject_ff,
  .mst_req_ff, .mst_retry, .mst_complete_ff, .status_ff, .passive_retry_ff);
`default_nettype wire

// ==== tb/pib_bridge_tb_top.sv ====
//==============================================================================
// Purpose: self checking bench of the bridge error and retry logic
// Assumes: refresh period shortened to 16 cycles
// Notes:   far side answers through the partner model
`timescale 1ns/1ps
`default_nettype none
module pib_bridge_tb_top;
  typedef struct packed {
    logic [3:0] cmd;
    logic [1:0] lo;
    logic [3:0] be_n;
    logic       isa;
    logic       cfg;
    logic [1:0] code;
  } pib_row_t;
  // answer codes: 0 none, 1 done, 2 abort, 3 retry
  pib_row_t rows [8] = '{
    '{pib_pkg::CMD_IO_RD, 2'h0, 4'he, 1'b1, 1'b0, 2'h1},
    '{pib_pkg::CMD_IO_WR, 2'h1, 4'h9, 1'b1, 1'b0, 2'h1},
    '{pib_pkg::CMD_IO_RD, 2'h0, 4'ha, 1'b1, 1'b0, 2'h2},
    '{pib_pkg::CMD_IO_WR, 2'h0, 4'h7, 1'b1, 1'b0, 2'h2},
    '{4'h6, 2'h0, 4'ha, 1'b1, 1'b0, 2'h1},
    '{pib_pkg::CMD_IO_RD, 2'h0, 4'hf, 1'b1, 1'b0, 2'h1},
    '{pib_pkg::CMD_CFG_RD, 2'h2, 4'hb, 1'b0, 1'b1, 2'h1},
    '{pib_pkg::CMD_IO_RD, 2'h0, 4'he, 1'b0, 1'b0, 2'h0}};
  logic clk = 1'b0, sys_rst = 1'b1, iochk_n = 1'b1, refresh_req_n = 1'b1, serr_enable = 1'b0;
  logic isa_dma_active = 1'b0, pcpci_dma_active = 1'b0, pcpci_dma_cycle = 1'b0;
  logic [2:0] pcpci_dma_chan = 3'h0;
  logic slow = 1'b0, arm_retry = 1'b0, serr_oe_ff, isa_done, refresh_start_ff, isa_dma_start_ff;
  logic [2:0] isa_dma_chan_ff;
  logic ism_reject_ff, mst_req_ff, mst_gnt, mst_retry, mst_done, mst_complete_ff, passive_retry_ff;
  logic [7:0] status_ff;
  pib_pkg::pib_tgt_req_t tgt_req = '0;
  pib_pkg::pib_tgt_rsp_t tgt_rsp_ff;
  pib_pkg::pib_isa_cyc_t isa_cyc_ff;
  pib_pkg::pib_mst_req_t ism_req = '0;
  int num_errors = 0, tests_run = 0, serr_cnt = 0, ref_cnt = 0, c0, s, i;
  logic [1:0] r_code;
  logic r_isa, r_serr;
  logic [31:0] r_data, mst_addr_ff;

  always #4 clk = ~clk;
  // pulse counters
  always @(posedge clk)
  begin
    serr_cnt += int'(serr_oe_ff === 1'b1);
    ref_cnt += int'(refresh_start_ff === 1'b1);
  end

  pib_bridge #(.REFRESH_PERIOD(16)) dut (.clk, .sys_rst, .ce(1'b1), .iochk_n,
    .isa_refresh_req_n(refresh_req_n), .serr_o_ff(), .serr_oe_ff, .serr_enable, .tgt_req,
    .tgt_rsp_ff, .isa_cyc_ff, .isa_done, .refresh_start_ff, .isa_dma_active, .pcpci_dma_active,
    .pcpci_dma_cycle, .pcpci_dma_chan, .isa_dma_start_ff, .isa_dma_chan_ff, .ism_req,
    .ism_reject_ff, .mst_req_ff, .mst_addr_ff, .mst_write_ff(), .mst_gnt, .mst_retry,
    .mst_done, .mst_complete_ff, .status_ff, .passive_retry_ff);
  pib_far_model u_far (.clk, .sys_rst, .slow, .arm_retry, .isa_valid(isa_cyc_ff.valid),
    .mst_req(mst_req_ff), .isa_done, .mst_gnt, .mst_retry, .mst_done);

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    tests_run++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // one target request, answer collected
  task automatic tgt(input logic [3:0] cmd, input logic [31:0] a, input logic [3:0] be,
                     input logic isa, input logic cfg);
    r_code = 2'h0;
    r_isa = 1'b0;
    r_serr = 1'b0;
    @(posedge clk);
    tgt_req <= '{1'b1, cmd, a, be, 32'h5a5a_0001, isa, cfg};
    for (int k = 0; k < 12 && r_code == 2'h0; k++)
    begin
      @(posedge clk);
      tgt_req.valid <= 1'b0;
      #1;
      r_isa |= isa_cyc_ff.valid === 1'b1;
      r_serr |= serr_oe_ff === 1'b1;
      r_data = tgt_rsp_ff.rdata;
      if (tgt_rsp_ff.done === 1'b1)
        r_code = tgt_rsp_ff.target_abort === 1'b1 ? 2'h2 : tgt_rsp_ff.retry === 1'b1 ? 2'h3 : 2'h1;
    end
  endtask

  initial
  begin
    repeat (5000) @(posedge clk);
    num_errors++;
    summarize();
  end

  initial
  begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    serr_enable <= 1'b1;
    @(posedge clk);
    #1;
    chk(status_ff, 32'h0000_0000, "status reset");
    for (s = 0; s < 2; s++)
    begin
      slow <= s[0];
      foreach (rows[j])
      begin
        tgt(rows[j].cmd, rows[j].cfg ? 32'h0000_0042 : 32'h0000_0300 | rows[j].lo, rows[j].be_n,
            rows[j].isa, rows[j].cfg);
        chk(r_code, rows[j].code, "answer");
        chk(r_isa, rows[j].code == 2'h1 && rows[j].isa, "isa forward");
        chk(r_serr, rows[j].code == 2'h2, "serr on abort");
        if (rows[j].cfg)
          chk(r_data, 32'h0001_0000, "config data");
      end
    end
    chk(status_ff, 32'h0000_0001, "lane error flag");
    tgt(pib_pkg::CMD_CFG_WR, 32'h0000_0042, 4'hb, 1'b0, 1'b1);
    chk(r_code, 2'h1, "config write answer");
    tgt(pib_pkg::CMD_CFG_RD, 32'h0000_0042, 4'hb, 1'b0, 1'b1);
    chk(r_data, 32'h0001_0000, "status after write");
    // channel check, held level gives one pulse
    c0 = serr_cnt;
    @(posedge clk);
    iochk_n <= 1'b0;
    repeat (8) @(posedge clk);
    #1;
    chk(status_ff, 32'h0000_0005, "channel check bit");
    chk(serr_cnt - c0, 32'h0000_0001, "serr pulses");
    // reset in mid run clears the sticky flag
    @(posedge clk);
    sys_rst <= 1'b1;
    @(posedge clk);
    sys_rst <= 1'b0;
    iochk_n <= 1'b1;
    #1;
    chk(status_ff, 32'h0000_0000, "status mid reset");
    // retried master cycle and passive retry
    @(posedge clk);
    slow <= 1'b1;
    arm_retry <= 1'b1;
    ism_req <= '{1'b1, 1'b1, 1'b0, 32'h0010_0000};
    @(posedge clk);
    arm_retry <= 1'b0;
    ism_req.valid <= 1'b0;
    for (i = 0; i < 10 && passive_retry_ff !== 1'b1; i++)
      @(posedge clk);
    #1;
    chk(passive_retry_ff, 1'b1, "passive retry");
    tgt(pib_pkg::CMD_IO_RD, 32'h0000_0300, 4'he, 1'b1, 1'b0);
    chk(r_code, 2'h3, "retry when passive");
    for (i = 0; i < 20 && mst_complete_ff !== 1'b1; i++)
      #8;
    chk({mst_complete_ff, passive_retry_ff}, 2'h2, "completion ends passive");
    chk(mst_addr_ff, 32'h0010_0000, "master address");
    // isa master i/o is refused
    @(posedge clk);
    ism_req <= '{1'b1, 1'b0, 1'b1, 32'h0000_0300};
    @(posedge clk);
    ism_req.valid <= 1'b0;
    #1;
    chk({ism_reject_ff, mst_req_ff}, 2'h2, "io refused");
    // both dma agents lock out target accesses
    for (i = 0; i < 2; i++)
    begin
      @(posedge clk);
      isa_dma_active <= i == 0;
      pcpci_dma_active <= i == 1;
      tgt(pib_pkg::CMD_CFG_RD, 32'h0000_0042, 4'hb, 1'b0, 1'b1);
      chk(r_code, 2'h3, "retry during dma");
    end
    @(posedge clk);
    pcpci_dma_active <= 1'b0;
    pcpci_dma_cycle <= 1'b1;
    pcpci_dma_chan <= 3'h5;
    @(posedge clk);
    pcpci_dma_cycle <= 1'b0;
    #1;
    chk({isa_dma_start_ff, isa_dma_chan_ff}, 4'hd, "isa dma start");
    // refresh: three ticks and one request in the window
    for (i = 0; i < 40 && refresh_start_ff !== 1'b1; i++)
      #8;
    @(posedge clk);
    refresh_req_n <= 1'b0;
    #1;
    c0 = ref_cnt;
    repeat (56) @(posedge clk);
    #1;
    chk(ref_cnt - c0, 32'h0000_0004, "refresh count");
    summarize();
  end
endmodule
`default_nettype wire
